// >>> amdc_auto_mute_dither_config.sv
// Notes on behaviour
// - Joint policy bit 2, resets to one
// - Policy zero: channels mute independently
// - Policy one: mute only when both qualify
// - Bit 1 enables right auto mute, reset one
// - Right disabled and joint: left never mutes
// - Bit 0 enables left auto mute, reset one
// - Left disabled and joint: right never mutes
// - Bits 7-6 left AC dither gain
// - Bits 5-4 right AC dither gain
// - Bits 3-2 left element dither gain
// - Bits 1-0 right element dither gain
// - DC dither added to left modulator low part
// - Zero code adds nothing, unit 2^-16 FS
// - DC code split over two registers
`timescale 1ns/1ps
`default_nettype none

module amdc_auto_mute_dither_config (
  input  wire logic                                core_clk_in,
  input  wire logic                                resetn_in,
  input  wire logic                                ce_in,
  input  wire logic [7:0]                          reg_addr_in,
  input  wire logic [7:0]                          reg_wdata_in,
  input  wire logic                                reg_wr_in,
  input  wire logic                                reg_rd_in,
  output logic      [7:0]                          reg_rdata_out,
  output logic                                     reg_rvalid_out,
  input  wire logic                                zero_left_in,
  input  wire logic                                zero_right_in,
  output logic                                     mute_left_out,
  output logic                                     mute_right_out,
  input  wire logic signed [23:0]                  left_mod_in,
  input  wire logic                                left_mod_valid_in,
  output logic signed [23:0]                       left_mod_out,
  output logic                                     left_mod_valid_out,
  output amdc_pkg::amdc_dither_cfg_type            dither_cfg_out,
  output amdc_pkg::amdc_mute_cfg_type              mute_cfg_out
);

  logic [7:0]         auto_mute_config_reg;
  logic [7:0]         primary_dither_gains_reg;
  logic [7:0]         left_primary_dc_dither_high_reg;
  logic [7:0]         left_primary_dc_dither_low_reg;
  logic [10:0]        dc_dither;
  logic               joint;
  logic [1:0]         enable;
  logic [1:0]         zero;
  logic [1:0]         mute_reg;
  logic [1:0]         mute_next;
  logic               both_qualify;
  logic [24:0]        dc_scaled;
  logic signed [24:0] mod_sum;
  logic signed [23:0] mod_sat;

  function automatic logic addr_is_mapped(input logic [7:0] addr);
    addr_is_mapped = (addr == amdc_pkg::AMDC_AUTO_MUTE_CONFIG_ADDR) ||
                     (addr == amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR) ||
                     (addr == amdc_pkg::AMDC_LEFT_DC_DITHER_HIGH_ADDR) ||
                     (addr == amdc_pkg::AMDC_LEFT_DC_DITHER_LOW_ADDR);
  endfunction

  function automatic logic signed [23:0] saturate(input logic signed [24:0] value);
    if (value[24] != value[23]) begin
      saturate = value[24] ? 24'sh800000 : 24'sh7FFFFF;
    end else begin
      saturate = value[23:0];
    end
  endfunction

  // Register writes; reserved bits are stored and read back
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      auto_mute_config_reg <= amdc_pkg::AMDC_AUTO_MUTE_CONFIG_RST;
    end else if (ce_in && reg_wr_in && reg_addr_in == amdc_pkg::AMDC_AUTO_MUTE_CONFIG_ADDR) begin
      auto_mute_config_reg <= reg_wdata_in;
    end
  end

  // Codes above 01 in the element fields are stored as written; the
  // scrambler treats them as undefined and software must avoid them.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      primary_dither_gains_reg <= amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_RST;
    end else if (ce_in && reg_wr_in && reg_addr_in == amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR) begin
      primary_dither_gains_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      left_primary_dc_dither_high_reg <= amdc_pkg::AMDC_LEFT_DC_DITHER_HIGH_RST;
      left_primary_dc_dither_low_reg  <= amdc_pkg::AMDC_LEFT_DC_DITHER_LOW_RST;
    end else if (ce_in && reg_wr_in) begin
      if (reg_addr_in == amdc_pkg::AMDC_LEFT_DC_DITHER_HIGH_ADDR) begin
        left_primary_dc_dither_high_reg <= reg_wdata_in;
      end
      if (reg_addr_in == amdc_pkg::AMDC_LEFT_DC_DITHER_LOW_ADDR) begin
        left_primary_dc_dither_low_reg <= reg_wdata_in;
      end
    end
  end

  // Read data is registered and answered one cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out  <= amdc_pkg::AMDC_UNMAPPED_READ;
      reg_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        if (!addr_is_mapped(reg_addr_in)) begin
          reg_rdata_out <= amdc_pkg::AMDC_UNMAPPED_READ;
        end else begin
          case (reg_addr_in)
            amdc_pkg::AMDC_AUTO_MUTE_CONFIG_ADDR:     reg_rdata_out <= auto_mute_config_reg;
            amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR: reg_rdata_out <= primary_dither_gains_reg;
            amdc_pkg::AMDC_LEFT_DC_DITHER_HIGH_ADDR:  reg_rdata_out <= left_primary_dc_dither_high_reg;
            default:                                  reg_rdata_out <= left_primary_dc_dither_low_reg;
          endcase
        end
      end
    end
  end

  assign dc_dither = {left_primary_dc_dither_high_reg[amdc_pkg::AMDC_DC_HIGH_W-1:0],
                      left_primary_dc_dither_low_reg};

  assign joint = auto_mute_config_reg[amdc_pkg::AMDC_JOINT_POLICY_BIT];
  assign enable[amdc_pkg::AMDC_CH_RIGHT] = auto_mute_config_reg[amdc_pkg::AMDC_ENABLE_BIT1_POS];
  assign enable[amdc_pkg::AMDC_CH_LEFT]  = auto_mute_config_reg[amdc_pkg::AMDC_ENABLE_BIT0_POS];
  assign zero[amdc_pkg::AMDC_CH_LEFT]    = zero_left_in;
  assign zero[amdc_pkg::AMDC_CH_RIGHT]   = zero_right_in;

  // A disabled channel never qualifies, so under joint policy it holds off both
  assign both_qualify = &(enable & zero);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_mute
      always_comb begin
        if (joint) begin
          mute_next[ch] = both_qualify;
        end else begin
          mute_next[ch] = enable[ch] & zero[ch];
        end
      end

      always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
          mute_reg[ch] <= 1'b0;
        end else if (ce_in) begin
          mute_reg[ch] <= mute_next[ch];
        end
      end
    end
  endgenerate

  assign mute_left_out  = mute_reg[amdc_pkg::AMDC_CH_LEFT];
  assign mute_right_out = mute_reg[amdc_pkg::AMDC_CH_RIGHT];

  // Dither lands 7 bits up: one code step is 2^-16 of full scale
  assign dc_scaled = {14'h0000, dc_dither} << amdc_pkg::AMDC_DC_SHIFT;
  assign mod_sum   = {left_mod_in[23], left_mod_in} + $signed(dc_scaled);
  assign mod_sat = saturate(mod_sum);

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      left_mod_out       <= 24'sh000000;
      left_mod_valid_out <= 1'b0;
    end else if (ce_in) begin
      left_mod_valid_out <= left_mod_valid_in;
      if (left_mod_valid_in) begin
        left_mod_out <= mod_sat;
      end
    end
  end

  always_comb begin
    dither_cfg_out.left_primary_ac_dither_gain =
      primary_dither_gains_reg[amdc_pkg::AMDC_LEFT_AC_LSB +: amdc_pkg::AMDC_GAIN_W];
    dither_cfg_out.right_primary_ac_dither_gain =
      primary_dither_gains_reg[amdc_pkg::AMDC_RIGHT_AC_LSB +: amdc_pkg::AMDC_GAIN_W];
    dither_cfg_out.left_primary_element_dither_gain =
      primary_dither_gains_reg[amdc_pkg::AMDC_LEFT_ELEM_LSB +: amdc_pkg::AMDC_GAIN_W];
    dither_cfg_out.right_primary_element_dither_gain =
      primary_dither_gains_reg[amdc_pkg::AMDC_RIGHT_ELEM_LSB +: amdc_pkg::AMDC_GAIN_W];
    dither_cfg_out.left_primary_dc_dither = dc_dither;
    mute_cfg_out.auto_mute_joint_policy = joint;
    mute_cfg_out.auto_mute_enable_bit1  = enable[amdc_pkg::AMDC_CH_RIGHT];
    mute_cfg_out.auto_mute_enable_bit0  = enable[amdc_pkg::AMDC_CH_LEFT];
  end

  property p_reset_defaults;
    @(posedge core_clk_in) !resetn_in |=> (auto_mute_config_reg[2:0] == 3'h7) && (primary_dither_gains_reg == 8'h00);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("auto-mute reset value wrong");

  property p_independent;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && !joint) |=> (mute_left_out == $past(enable[0] & zero_left_in)) &&
                            (mute_right_out == $past(enable[1] & zero_right_in));
  endproperty
  a_independent: assert property (p_independent) else $error("independent mute mismatch");

  property p_joint;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && joint && zero_left_in && zero_right_in && enable == 2'h3) |=> (mute_left_out && mute_right_out);
  endproperty
  a_joint: assert property (p_joint) else $error("joint mute not applied");

  property p_joint_single;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && joint && !(zero_left_in && zero_right_in)) |=> (!mute_left_out && !mute_right_out);
  endproperty
  a_joint_single: assert property (p_joint_single) else $error("joint mute on one channel");

  property p_right_disabled;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && !enable[1]) |=> !mute_right_out;
  endproperty
  a_right_disabled: assert property (p_right_disabled) else $error("right muted while disabled");

  property p_right_blocks_left;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && !enable[1] && joint) |=> !mute_left_out;
  endproperty
  a_right_blocks_left: assert property (p_right_blocks_left) else $error("left muted, right disabled");

  property p_left_disabled;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && !enable[0]) |=> !mute_left_out;
  endproperty
  a_left_disabled: assert property (p_left_disabled) else $error("left muted while disabled");

  property p_left_blocks_right;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && !enable[0] && joint) |=> !mute_right_out;
  endproperty
  a_left_blocks_right: assert property (p_left_blocks_right) else $error("right muted, left disabled");

  property p_ac_gains;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && reg_wr_in && reg_addr_in == 8'h43) |=>
        dither_cfg_out.left_primary_ac_dither_gain == $past(reg_wdata_in[7:6]) &&
        dither_cfg_out.right_primary_ac_dither_gain == $past(reg_wdata_in[5:4]);
  endproperty
  a_ac_gains: assert property (p_ac_gains) else $error("AC dither gain field wrong");

  property p_elem_gains;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && reg_wr_in && reg_addr_in == 8'h43) |=>
        dither_cfg_out.left_primary_element_dither_gain == $past(reg_wdata_in[3:2]) &&
        dither_cfg_out.right_primary_element_dither_gain == $past(reg_wdata_in[1:0]);
  endproperty
  a_elem_gains: assert property (p_elem_gains) else $error("element dither gain field wrong");

  property p_dc_high;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && reg_wr_in && reg_addr_in == 8'h44) |=> dc_dither[10:8] == $past(reg_wdata_in[2:0]);
  endproperty
  a_dc_high: assert property (p_dc_high) else $error("DC dither high bits wrong");

  property p_dither_add;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && left_mod_valid_in && left_mod_in < 24'sh700000) |=>
        left_mod_valid_out && (left_mod_out == $past(left_mod_in) + $signed({6'h00, $past(dc_dither), 7'h00}));
  endproperty
  a_dither_add: assert property (p_dither_add) else $error("DC dither not added");

  property p_zero_dither;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && left_mod_valid_in && dc_dither == 11'h000) |=> left_mod_out == $past(left_mod_in);
  endproperty
  a_zero_dither: assert property (p_zero_dither) else $error("zero dither changed sample");

  property p_dc_low;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && reg_wr_in && reg_addr_in == amdc_pkg::AMDC_LEFT_DC_DITHER_LOW_ADDR) |=>
        dc_dither[7:0] == $past(reg_wdata_in);
  endproperty
  a_dc_low: assert property (p_dc_low) else $error("DC dither low bits wrong");

  property p_no_wrap;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && left_mod_valid_in && !left_mod_in[23]) |=> !left_mod_out[23];
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("dithered sample wrapped negative");

  property p_mute_cfg_map;
    @(posedge core_clk_in) disable iff (!resetn_in)
      ce_in |-> mute_cfg_out.auto_mute_joint_policy == auto_mute_config_reg[2] &&
                mute_cfg_out.auto_mute_enable_bit1 == auto_mute_config_reg[1] &&
                mute_cfg_out.auto_mute_enable_bit0 == auto_mute_config_reg[0];
  endproperty
  a_mute_cfg_map: assert property (p_mute_cfg_map) else $error("mute config fields misplaced");

  property p_read_answer;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && reg_rd_in && reg_addr_in == amdc_pkg::AMDC_AUTO_MUTE_CONFIG_ADDR) |=>
        reg_rvalid_out && reg_rdata_out == $past(auto_mute_config_reg);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("auto-mute readback wrong");

endmodule

`default_nettype wire

// >>> amdc_pkg.sv
`default_nettype none

package amdc_pkg;

  // Register offsets on the control port
  localparam logic [7:0] AMDC_AUTO_MUTE_CONFIG_ADDR      = 8'h41;
  localparam logic [7:0] AMDC_PRIMARY_DITHER_GAINS_ADDR  = 8'h43;
  localparam logic [7:0] AMDC_LEFT_DC_DITHER_HIGH_ADDR   = 8'h44;
  localparam logic [7:0] AMDC_LEFT_DC_DITHER_LOW_ADDR    = 8'h45;

  // Reset values
  localparam logic [7:0] AMDC_AUTO_MUTE_CONFIG_RST       = 8'h07;
  localparam logic [7:0] AMDC_PRIMARY_DITHER_GAINS_RST   = 8'h00;
  localparam logic [7:0] AMDC_LEFT_DC_DITHER_HIGH_RST    = 8'h00;
  localparam logic [7:0] AMDC_LEFT_DC_DITHER_LOW_RST     = 8'h00;
  localparam logic [7:0] AMDC_UNMAPPED_READ              = 8'h00;

  // Auto-mute register field positions
  localparam int AMDC_JOINT_POLICY_BIT  = 2;
  localparam int AMDC_ENABLE_BIT1_POS   = 1;
  localparam int AMDC_ENABLE_BIT0_POS   = 0;

  // Dither gain register field positions (low bit of each 2-bit field)
  localparam int AMDC_LEFT_AC_LSB       = 6;
  localparam int AMDC_RIGHT_AC_LSB      = 4;
  localparam int AMDC_LEFT_ELEM_LSB     = 2;
  localparam int AMDC_RIGHT_ELEM_LSB    = 0;
  localparam int AMDC_GAIN_W            = 2;

  // DC dither split: 3 high bits, 8 low bits
  localparam int AMDC_DC_HIGH_W         = 3;
  localparam int AMDC_DC_LOW_W          = 8;
  localparam int AMDC_DC_W              = 11;

  // Modulator input: signed 24-bit, full scale 2^23.
  // One dither unit is 2^-11 * 1/32 FS = 2^-16 FS = 2^7 LSB.
  localparam int AMDC_MOD_W             = 24;
  localparam int AMDC_DC_SHIFT          = 7;
  localparam int AMDC_SUM_W             = 25;

  // Channel indices
  localparam int AMDC_CH_LEFT           = 0;
  localparam int AMDC_CH_RIGHT          = 1;

  typedef struct packed {
    logic [1:0] left_primary_ac_dither_gain;
    logic [1:0] right_primary_ac_dither_gain;
    logic [1:0] left_primary_element_dither_gain;
    logic [1:0] right_primary_element_dither_gain;
    logic [10:0] left_primary_dc_dither;
  } amdc_dither_cfg_type;

  typedef struct packed {
    logic       auto_mute_joint_policy;
    logic       auto_mute_enable_bit1;
    logic       auto_mute_enable_bit0;
  } amdc_mute_cfg_type;

endpackage

`default_nettype wire

// >>> amdc_testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                          core_clk_in;
  logic                          resetn_in;
  logic                          ce_in;
  logic [7:0]                    reg_addr_in;
  logic [7:0]                    reg_wdata_in;
  logic                          reg_wr_in;
  logic                          reg_rd_in;
  logic [7:0]                    reg_rdata_out;
  logic                          reg_rvalid_out;
  logic                          zero_left_in;
  logic                          zero_right_in;
  logic                          mute_left_out;
  logic                          mute_right_out;
  logic signed [23:0]            left_mod_in;
  logic                          left_mod_valid_in;
  logic signed [23:0]            left_mod_out;
  logic                          left_mod_valid_out;
  amdc_pkg::amdc_dither_cfg_type dither_cfg_out;
  amdc_pkg::amdc_mute_cfg_type   mute_cfg_out;
  int                            num_errors = 0;
  int                            tests_run = 0;
  int                            cycle_count = 0;

  amdc_auto_mute_dither_config dut_u (
    .core_clk_in        (core_clk_in),
    .resetn_in          (resetn_in),
    .ce_in              (ce_in),
    .reg_addr_in        (reg_addr_in),
    .reg_wdata_in       (reg_wdata_in),
    .reg_wr_in          (reg_wr_in),
    .reg_rd_in          (reg_rd_in),
    .reg_rdata_out      (reg_rdata_out),
    .reg_rvalid_out     (reg_rvalid_out),
    .zero_left_in       (zero_left_in),
    .zero_right_in      (zero_right_in),
    .mute_left_out      (mute_left_out),
    .mute_right_out     (mute_right_out),
    .left_mod_in        (left_mod_in),
    .left_mod_valid_in  (left_mod_valid_in),
    .left_mod_out       (left_mod_out),
    .left_mod_valid_out (left_mod_valid_out),
    .dither_cfg_out     (dither_cfg_out),
    .mute_cfg_out       (mute_cfg_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 200 cycles the tests need
  always @(posedge core_clk_in) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      num_errors++;
      final_report;
    end
  end

  task automatic tick;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Strobe is lowered and an edge passes, so back-to-back calls never re-raise it in one step
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    reg_addr_in = addr;
    reg_wdata_in = data;
    reg_wr_in = 1'b1;
    tick;
    reg_wr_in = 1'b0;
    tick;
  endtask

  task automatic reg_check(input logic [7:0] addr, input logic [7:0] exp);
    reg_addr_in = addr;
    reg_rd_in = 1'b1;
    tick;
    reg_rd_in = 1'b0;
    check("rvalid", {31'h0, reg_rvalid_out}, 32'h1);
    check("rdata", {24'h0, reg_rdata_out}, {24'h0, exp});
    tick;
    check("rvalid drop", {31'h0, reg_rvalid_out}, 32'h0);
  endtask

  task automatic test_reset;
    reg_check(amdc_pkg::AMDC_AUTO_MUTE_CONFIG_ADDR, 8'h07);
    reg_check(amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR, 8'h00);
    reg_check(amdc_pkg::AMDC_LEFT_DC_DITHER_HIGH_ADDR, 8'h00);
    reg_check(amdc_pkg::AMDC_LEFT_DC_DITHER_LOW_ADDR, 8'h00);
    reg_check(8'h42, 8'h00);
    check("mute cfg", {29'h0, mute_cfg_out}, 32'h7);
    check("dither cfg", {13'h0, dither_cfg_out}, 32'h0);
    $display("test reset done");
  endtask

  task automatic test_gains;
    logic [7:0] pat [6] = '{8'h40, 8'h10, 8'h04, 8'h01, 8'h55, 8'h00};
    foreach (pat[i]) begin
      reg_write(amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR, pat[i]);
      check("left ac", {30'h0, dither_cfg_out.left_primary_ac_dither_gain}, {30'h0, pat[i][7:6]});
      check("right ac", {30'h0, dither_cfg_out.right_primary_ac_dither_gain}, {30'h0, pat[i][5:4]});
      check("left elem", {30'h0, dither_cfg_out.left_primary_element_dither_gain}, {30'h0, pat[i][3:2]});
      check("right elem", {30'h0, dither_cfg_out.right_primary_element_dither_gain}, {30'h0, pat[i][1:0]});
      reg_check(amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR, pat[i]);
    end
    // A write with the clock enable low must not land
    ce_in = 1'b0;
    reg_write(amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR, 8'h11);
    ce_in = 1'b1;
    reg_check(amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR, 8'h00);
    $display("test gains done");
  endtask

  task automatic test_dc;
    logic [10:0]        dc [5] = '{11'h000, 11'h001, 11'h5A3, 11'h7FF, 11'h000};
    logic signed [23:0] smp [5] = '{24'h123456, 24'h000000, -24'sh1000, 24'h7FFF00, 24'h800000};
    logic signed [23:0] exp_v;
    int                 sum;
    // Reserved high bits stored, but only the low three feed the code
    reg_write(amdc_pkg::AMDC_LEFT_DC_DITHER_HIGH_ADDR, 8'hFD);
    reg_write(amdc_pkg::AMDC_LEFT_DC_DITHER_LOW_ADDR, 8'h3C);
    check("dc code", {21'h0, dither_cfg_out.left_primary_dc_dither}, 32'h53C);
    reg_check(amdc_pkg::AMDC_LEFT_DC_DITHER_HIGH_ADDR, 8'hFD);
    reg_check(amdc_pkg::AMDC_LEFT_DC_DITHER_LOW_ADDR, 8'h3C);
    foreach (dc[i]) begin
      reg_write(amdc_pkg::AMDC_LEFT_DC_DITHER_HIGH_ADDR, {5'h00, dc[i][10:8]});
      reg_write(amdc_pkg::AMDC_LEFT_DC_DITHER_LOW_ADDR, dc[i][7:0]);
      sum = int'(smp[i]) + int'(dc[i]) * 128;
      if (sum > 32'sh7FFFFF) begin
        sum = 32'sh7FFFFF;
      end
      exp_v = sum[23:0];
      left_mod_in = smp[i];
      left_mod_valid_in = 1'b1;
      tick;
      left_mod_valid_in = 1'b0;
      check("mod valid", {31'h0, left_mod_valid_out}, 32'h1);
      check("mod out", {8'h00, left_mod_out}, {8'h00, exp_v});
      tick;
      check("mod valid drop", {31'h0, left_mod_valid_out}, 32'h0);
    end
    $display("test dc dither done");
  endtask

  task automatic test_mute;
    logic [4:0] v;
    logic       lq;
    logic       rq;
    logic       ml;
    logic       mr;
    for (int i = 0; i < 32; i++) begin
      v = i[4:0];
      reg_write(amdc_pkg::AMDC_AUTO_MUTE_CONFIG_ADDR, {5'h00, v[4:2]});
      zero_left_in = v[1];
      zero_right_in = v[0];
      tick;
      lq = v[1] & v[2];
      rq = v[0] & v[3];
      ml = v[4] ? (lq & rq) : lq;
      mr = v[4] ? (lq & rq) : rq;
      check("mute left", {31'h0, mute_left_out}, {31'h0, ml});
      check("mute right", {31'h0, mute_right_out}, {31'h0, mr});
      check("mute cfg", {29'h0, mute_cfg_out}, {29'h0, v[4:2]});
    end
    zero_left_in = 1'b0;
    zero_right_in = 1'b0;
    // Reserved bits are stored and read back
    reg_write(amdc_pkg::AMDC_AUTO_MUTE_CONFIG_ADDR, 8'hAD);
    reg_check(amdc_pkg::AMDC_AUTO_MUTE_CONFIG_ADDR, 8'hAD);
    $display("test mute done");
  endtask

  initial begin
    resetn_in = 1'b0;
    ce_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    zero_left_in = 1'b0;
    zero_right_in = 1'b0;
    left_mod_in = 24'h000000;
    left_mod_valid_in = 1'b0;
    repeat (5) @(posedge core_clk_in);
    #1;
    resetn_in = 1'b1;
    test_reset;
    test_gains;
    test_dc;
    test_mute;
    // Mid-run reset must act even with the clock enable low
    reg_write(amdc_pkg::AMDC_PRIMARY_DITHER_GAINS_ADDR, 8'h55);
    ce_in = 1'b0;
    resetn_in = 1'b0;
    tick;
    resetn_in = 1'b1;
    ce_in = 1'b1;
    test_reset;
    final_report;
  end
endmodule

`default_nettype wire
